// [bench/bmx_mst_model.sv]
`timescale 1ns/1ps
// Five bus masters issuing single address phases
module bmx_mst_model (
  // Address phases
  output logic [159:0] o_haddr,
  output logic [4:0] o_htrans_valid,
  output logic [4:0] o_hready
);
  // Idle masters, bus always ready
  initial begin
    o_haddr = '0;
    o_htrans_valid = 5'h00;
    o_hready = 5'h1F;
  end
  // Each master owns its own address lane
  task put(input int m, input logic [31:0] a);
    o_haddr[m*32+:32] <= a;
    o_htrans_valid[m] <= 1'b1;
  endtask
  // Released lanes show inverted data, not the old address
  task clear();
    o_htrans_valid <= 5'h00;
    o_haddr <= ~o_haddr;
  endtask
endmodule

// [bench/bmx_top_sva.sv]
`timescale 1ns/1ps
module bmx_top_sva #(
  parameter int NUM_MASTERS = 5,
  parameter int NUM_SLAVES = 5
) (
  // Clock, reset and inputs
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [NUM_MASTERS-1:0] i_remap_ctrl,
  input wire logic [NUM_MASTERS*32-1:0] i_haddr,
  input wire logic [NUM_MASTERS-1:0] i_htrans_valid,
  input wire logic [NUM_MASTERS-1:0] i_hready,
  // Outputs watched
  input wire logic [NUM_MASTERS*NUM_SLAVES-1:0] o_slave_sel,
  input wire logic [NUM_MASTERS-1:0] o_sysp_sel,
  input wire logic [NUM_MASTERS-1:0] o_abort_resp,
  input wire logic [NUM_MASTERS-1:0] o_abort_ready,
  input wire logic [NUM_SLAVES*NUM_MASTERS-1:0] o_grant,
  input wire logic [7:0] o_ext_chip_select_n,
  input wire logic o_boot_from_rom,
  input wire logic [3:0] o_ext_boot_cfg,
  input wire logic [NUM_MASTERS-1:0] o_remap_active
);
  // Master 0 address phase fields
  wire tk = i_htrans_valid[0] && i_hready[0];
  wire [3:0] ar = i_haddr[31:28];
  wire [11:0] pg = i_haddr[31:20];
  wire rm = i_remap_ctrl[0] && o_remap_active[0];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Two-cycle error answer
  sequence s_abort2;
    !o_abort_ready[0] ##1 (o_abort_resp[0] && o_abort_ready[0])
      ##1 !o_abort_resp[0];
  endsequence
  sequence s_ext_take;
    tk && ar == 4'h1 ##1 o_grant[15];
  endsequence
  a_abort_two_cycles: assert property ($rose(o_abort_resp[0]) |-> s_abort2)
    else $error("abort answer shape wrong");
  a_unused_area_abort: assert property (tk && ar > 4'h8 && ar < 4'hF &&
    !o_abort_resp[0] |=> o_abort_resp[0] && o_slave_sel[4:0] == 5'h00)
    else $error("unused area not aborted");
  a_ext_area_sel: assert property (tk && ar >= 4'h1 && ar <= 4'h8
    |=> o_slave_sel[4:0] == 5'h08) else $error("ext area sel");
  a_periph_area_sel: assert property (tk && ar == 4'hF
    |=> o_slave_sel[4:0] == 5'h10) else $error("periph sel");
  a_sysp_top_sel: assert property (tk
    |=> o_sysp_sel[0] == ($past(i_haddr[31:0]) >= 32'hFFFFEA00))
    else $error("sysp window");
  a_rom_fixed_base: assert property (tk && pg == 12'h004
    |=> o_slave_sel[1]) else $error("rom base");
  a_hostif_fixed_base: assert property (tk && (pg == 12'h005 ||
    pg == 12'h006) |=> o_slave_sel[2]) else $error("hostif base");
  a_remap_sram_zero: assert property (tk && pg == 12'h000 && rm
    |=> o_slave_sel[4:0] == 5'h01) else $error("remap sram");
  a_boot_zero_sel: assert property (tk && pg == 12'h000 &&
    !i_remap_ctrl[0] && !o_remap_active[0] |=> o_slave_sel[4:0] ==
    (o_boot_from_rom ? 5'h02 : 5'h08)) else $error("boot alias");
  a_ext_cs_zero: assert property (s_ext_take
    |=> o_ext_chip_select_n == 8'hFE) else $error("chip select");
  a_boot_cfg_follow: assert property (o_ext_boot_cfg ==
    {4{!$past(o_boot_from_rom)}}) else $error("boot cfg");
  a_remap_reset_clear: assert property (@(posedge i_clock) disable iff (1'b0)
    i_rst |=> o_remap_active == '0) else $error("remap reset");
endmodule
bind bmx_top bmx_top_sva #(.NUM_MASTERS(NUM_MASTERS),
  .NUM_SLAVES(NUM_SLAVES)) bmx_top_sva_inst (.*);

// [bench/bmx_top_test.sv]
`timescale 1ns/1ps
module bmx_top_test;
  // Bench signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic boot_memory_select = 1'b1;
  logic [4:0] remap = 5'h00;
  logic [159:0] haddr;
  logic [4:0] hvalid, hready, sysp, abrt, abrdy, rma;
  logic [24:0] sel, grant;
  logic [7:0] cs_n;
  logic rom;
  logic [3:0] cfg;
  int errors = 0;
  int n_compared = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  bmx_mst_model bmx_mst_model_inst (.o_haddr(haddr),
    .o_htrans_valid(hvalid), .o_hready(hready));
  bmx_top bmx_top_inst (.i_clock(clk), .i_rst(rst),
    .i_boot_memory_select(boot_memory_select), .i_remap_ctrl(remap), .i_haddr(haddr),
    .i_htrans_valid(hvalid), .i_hready(hready), .i_arb_mode(10'h000),
    .i_arb_fixed_master(15'h0000), .i_slave_busy(5'h00),
    .o_slave_sel(sel), .o_sysp_sel(sysp), .o_abort_resp(abrt),
    .o_abort_ready(abrdy), .o_grant(grant), .o_ext_chip_select_n(cs_n),
    .o_boot_from_rom(rom), .o_ext_boot_cfg(cfg), .o_remap_active(rma));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One address phase, sampled once the decode has registered
  task xfer(input int m, input logic [31:0] a);
    @(posedge clk);
    bmx_mst_model_inst.put(m, a);
    @(posedge clk);
    bmx_mst_model_inst.clear();
    #1;
  endtask
  task chk_abort(input int m);
    chk("abort", 2'b10, {abrt[m], abrdy[m]});
    tick(1);
    chk("abort", 2'b11, {abrt[m], abrdy[m]});
    tick(1);
    chk("abort", 2'b00, {abrt[m], abrdy[m]});
    tick(1);
  endtask
  task do_reset(input logic b);
    @(posedge clk);
    boot_memory_select <= b;
    rst <= 1'b1;
    remap <= 5'h00;
    tick(4);
    rst <= 1'b0;
    tick(3);
    chk("boot", b, rom);
    chk("cfg", {4{~b}}, cfg);
    chk("remap", 5'h00, rma);
  endtask
  task t_areas;
    logic [4:0] e;
    for (int a = 0; a < 16; a++) begin
      xfer(0, {a[3:0], 28'h0000100});
      e = (a == 0) ? 5'h02 : (a <= 8) ? 5'h08 : (a == 15) ? 5'h10 : 5'h00;
      chk("sel", e, sel[4:0]);
      if (e == 5'h00) chk_abort(0);
      else tick(2);
    end
    $display("t_areas done");
  endtask
  task t_internal;
    logic [31:0] ad [5] = '{32'h00400000, 32'h00500000, 32'h00600000,
      32'h00300000, 32'h00700000};
    logic [4:0] ex [5] = '{5'h02, 5'h04, 5'h04, 5'h01, 5'h00};
    for (int i = 0; i < 5; i++) begin
      xfer(1, ad[i]);
      chk("isel", ex[i], sel[9:5]);
    end
    chk_abort(1);
    xfer(0, 32'hFFFFEA00);
    chk("sysp", 1'b1, sysp[0]);
    xfer(0, 32'hFFFFE9FC);
    chk("sysp", 1'b0, sysp[0]);
    $display("t_internal done");
  endtask
  task t_remap;
    remap <= 5'h01;
    tick(2);
    xfer(0, 32'h00000010);
    chk("rsel0", 5'h01, sel[4:0]);
    xfer(1, 32'h00000010);
    chk("rsel1", 5'h02, sel[9:5]);
    xfer(2, 32'h00000010);
    chk("rsel2", 5'h00, sel[14:10]);
    chk_abort(2);
    remap <= 5'h05;
    tick(2);
    xfer(2, 32'h00000010);
    chk("rsel2", 5'h01, sel[14:10]);
    xfer(0, 32'h00400000);
    chk("rom", 5'h02, sel[4:0]);
    chk("ract", 5'h05, rma);
    $display("t_remap done");
  endtask
  task t_ext_boot;
    do_reset(1'b0);
    xfer(1, 32'h00000020);
    chk("esel", 5'h08, sel[9:5]);
    tick(1);
    chk("cs0", 8'hFE, cs_n);
    xfer(0, 32'h80000000);
    chk("grant", 5'h01, grant[19:15]);
    tick(1);
    chk("cs7", 8'h7F, cs_n);
    chk("cfg hold", 4'hF, cfg);
    $display("t_ext_boot done");
  endtask
  task t_arb;
    logic [4:0] g;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      bmx_mst_model_inst.put(1, 32'h00300000);
      bmx_mst_model_inst.put(2, 32'h00300000);
      @(posedge clk);
      bmx_mst_model_inst.clear();
      #1;
      chk("both", 10'h021, {sel[14:10], sel[9:5]});
      if (k == 0) g = grant[4:0];
      chk("grant", (k == 0) ? 5'h02 : 5'h06, (k == 0) ? g : g ^
        grant[4:0]);
      chk("gone", 1'b1, grant[4:0] == 5'h02 || grant[4:0] == 5'h04);
      tick(2);
    end
    $display("t_arb done");
  endtask
  task conclude;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset(1'b1);
    t_areas();
    t_internal();
    t_remap();
    t_ext_boot();
    t_arb();
    conclude();
  end
  // Watchdog well beyond the expected run
  initial begin
    #(40 * 4000);
    errors++;
    conclude();
  end
endmodule

// [hdl/bmx_arbiter.sv]
`timescale 1ns/1ps

module bmx_arbiter #(
  parameter int NUM_MASTERS = 5
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Requests and policy
  input wire logic [NUM_MASTERS-1:0] i_req,
  input wire logic i_busy,
  input wire logic [1:0] i_mode,
  input wire logic [2:0] i_fixed_master,
  // Grant
  output logic [NUM_MASTERS-1:0] o_grant
);

  logic [NUM_MASTERS-1:0] grant_reg;
  logic [NUM_MASTERS-1:0] grant_next;
  logic [NUM_MASTERS-1:0] last_reg;
  logic [NUM_MASTERS-1:0] rr_pick;
  logic [NUM_MASTERS-1:0] idle_pick;

  // Round robin: first request after the last owner
  always_comb begin
    int k;
    int idx;
    k = 0;
    idx = 0;
    rr_pick = '0;
    for (k = 0; k < NUM_MASTERS; k++) begin
      if (last_reg[k]) begin
        idx = k;
      end
    end
    for (k = 1; k <= NUM_MASTERS; k++) begin
      if (rr_pick == '0 && i_req[(idx + k) % NUM_MASTERS]) begin
        rr_pick[(idx + k) % NUM_MASTERS] = 1'b1;
      end
    end
  end

  // Owner when nobody requests, per the slave's own mode
  assign idle_pick =
    (i_mode == bmx_pkg::BMX_ARB_LAST_DEFAULT) ? last_reg :
    (i_mode == bmx_pkg::BMX_ARB_FIXED_DEFAULT) ?
      NUM_MASTERS'(1 << i_fixed_master) : '0;
  assign grant_next = i_busy ? grant_reg :
                      ((i_req != '0) ? rr_pick : idle_pick);

  // Grant and last owner registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      grant_reg <= '0;
      last_reg <= NUM_MASTERS'(1);
    end else begin
      grant_reg <= grant_next;
      if (grant_next != '0) begin
        last_reg <= grant_next;
      end
    end
  end

  assign o_grant = grant_reg;

endmodule

// [hdl/bmx_dec_if.sv]
`timescale 1ns/1ps
// Address phase of one master towards its own decoder
interface bmx_dec_if;
  logic [31:0] addr;
  logic valid;
  logic remap;
  logic boot_rom;
  logic [4:0] sel;
  logic [7:0] cs_n;
  logic abort;
  logic sysp;
  modport dec (
    input addr, valid, remap, boot_rom,
    output sel, cs_n, abort, sysp
  );
  modport host (
    output addr, valid, remap, boot_rom,
    input sel, cs_n, abort, sysp
  );
endinterface

// [hdl/bmx_decoder.sv]
`timescale 1ns/1ps
`include "bmx_params.svh"

module bmx_decoder #(
  parameter bit BOOT_ALIAS = 1'b1
) (
  bmx_dec_if.dec dif
);

  wire [3:0] area;
  wire [7:0] sub;
  wire is_int;
  wire is_ext;
  wire is_per;
  wire in_boot;
  wire boot_sram;
  wire boot_rom;
  wire boot_ext;
  wire sram_hit;
  wire rom_hit;
  wire host_hit;
  wire [3:0] ext_idx;
  wire [4:0] raw_sel;
  wire [7:0] cs_hot;

  // Area and internal window split
  assign area = dif.addr[`BMX_AREA_HI:`BMX_AREA_LO];
  assign sub = dif.addr[`BMX_SUB_HI:`BMX_SUB_LO];
  assign is_int = (area == `BMX_AREA_INT);
  assign is_ext = (area >= `BMX_AREA_EXT_FIRST) &&
                  (area <= `BMX_AREA_EXT_LAST);
  assign is_per = (area == `BMX_AREA_PERIPH);
  assign in_boot = is_int && (sub == `BMX_SUB_BOOT);

  // Boot window at zero: remap first, then the latched boot select
  assign boot_sram = in_boot && dif.remap;
  assign boot_rom = in_boot && !dif.remap && BOOT_ALIAS &&
                    dif.boot_rom;
  assign boot_ext = in_boot && !dif.remap && BOOT_ALIAS &&
                    !dif.boot_rom;

  // Fixed bases, independent of remap and boot select
  assign sram_hit = is_int && (sub == `BMX_SUB_SRAM);
  assign rom_hit = is_int && (sub == `BMX_SUB_ROM);
  assign host_hit = is_int && ((sub == `BMX_SUB_USBH) ||
                    (sub == `BMX_SUB_DISP));

  // Slave select, external memories only through slave 3
  assign raw_sel[`BMX_SLV_SRAM] = sram_hit || boot_sram;
  assign raw_sel[`BMX_SLV_ROM] = rom_hit || boot_rom;
  assign raw_sel[`BMX_SLV_HOSTIF] = host_hit;
  assign raw_sel[`BMX_SLV_EBI] = is_ext || boot_ext;
  assign raw_sel[`BMX_SLV_PERIPH] = is_per;
  assign dif.sel = dif.valid ? raw_sel : 5'h00;

  // Chip select per area, select zero for the external boot
  assign ext_idx = is_ext ? (area - 4'h1) : 4'h0;
  assign cs_hot = (is_ext || boot_ext) ?
                  (8'h01 << ext_idx[2:0]) : 8'h00;
  assign dif.cs_n = dif.valid ? ~cs_hot : 8'hFF;

  // Unmapped accesses and the system peripheral window
  assign dif.abort = dif.valid && (raw_sel == 5'h00);
  assign dif.sysp = dif.valid && is_per &&
                    (dif.addr >= `BMX_SYSP_BASE);

endmodule

// [hdl/bmx_params.svh]
`ifndef BMX_PARAMS_SVH
`define BMX_PARAMS_SVH

// Address map, first level: sixteen 256 MB areas on bits 31..28
`define BMX_AREA_HI 31
`define BMX_AREA_LO 28
`define BMX_AREA_INT 4'h0
`define BMX_AREA_EXT_FIRST 4'h1
`define BMX_AREA_EXT_LAST 4'h8
`define BMX_AREA_PERIPH 4'hF

// Second level inside area 0: 1 MB windows on bits 27..20
`define BMX_SUB_HI 27
`define BMX_SUB_LO 20
`define BMX_SUB_BOOT 8'h00
`define BMX_SUB_SRAM 8'h03
`define BMX_SUB_ROM 8'h04
`define BMX_SUB_USBH 8'h05
`define BMX_SUB_DISP 8'h06

// System controller peripherals: top 5.5 KB of the space
`define BMX_SYSP_BASE 32'hFFFFEA00

// Slave numbers of the matrix
`define BMX_SLV_SRAM 0
`define BMX_SLV_ROM 1
`define BMX_SLV_HOSTIF 2
`define BMX_SLV_EBI 3
`define BMX_SLV_PERIPH 4

// External boot configuration bits
`define BMX_EBOOT_SLOW_CLK 0
`define BMX_EBOOT_BYTE_SEL 1
`define BMX_EBOOT_BUS16 2
`define BMX_EBOOT_RW_BY_CS 3

// Reset values
`define BMX_BOOT_SEL_RST 1'b1
`define BMX_REMAP_RST 5'h00

`endif

// [hdl/bmx_pkg.sv]
package bmx_pkg;

  // Abort response sequencer states, one-hot
  typedef enum logic [2:0] {
    BMX_ERR_IDLE = 3'h1,
    BMX_ERR_FIRST = 3'h2,
    BMX_ERR_SECOND = 3'h4
  } bmx_err_state_t;

  // Arbitration modes of a slave
  typedef enum logic [1:0] {
    BMX_ARB_NO_DEFAULT = 2'h0,
    BMX_ARB_LAST_DEFAULT = 2'h1,
    BMX_ARB_FIXED_DEFAULT = 2'h2
  } bmx_arb_mode_t;

endpackage

// [hdl/bmx_top.sv]
// What this block does
// - Sixteen 256 MB areas route each access.
// - Areas 1-8 go external, one chip select each.
// - Area 0 second decode, 1 MB internal windows.
// - Area 15 goes to the peripheral bus slave.
// - Unused areas answer the master with abort.
// - Every master has its own decoder.
// - Every slave has its own arbiter.
// - Masters 0,1 pick three slaves at zero.
// - Per-master remap puts SRAM at zero.
// - Boot select latched at reset picks ROM/external.
// - ROM always decodes at its fixed base.
// - USB host registers decode at fixed base.
// - Display interface decodes at fixed base.
// - Unaffected memories stay at their bases.
// - System peripherals sit in the top 5.5 KB.
// - External memory only through slave three.
// - External boot: slow clock, 16-bit byte-select.
`timescale 1ns/1ps
`include "bmx_params.svh"

module bmx_top #(
  parameter int NUM_MASTERS = 5,
  parameter int NUM_SLAVES = 5,
  parameter int NUM_BOOT_MASTERS = 2
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Boot strap pin and remap controls
  input wire logic i_boot_memory_select,
  input wire logic [NUM_MASTERS-1:0] i_remap_ctrl,
  // Master address phases
  input wire logic [NUM_MASTERS*32-1:0] i_haddr,
  input wire logic [NUM_MASTERS-1:0] i_htrans_valid,
  input wire logic [NUM_MASTERS-1:0] i_hready,
  // Arbitration policy and slave state
  input wire logic [NUM_SLAVES*2-1:0] i_arb_mode,
  input wire logic [NUM_SLAVES*3-1:0] i_arb_fixed_master,
  input wire logic [NUM_SLAVES-1:0] i_slave_busy,
  // Decode results per master
  output logic [NUM_MASTERS*NUM_SLAVES-1:0] o_slave_sel,
  output logic [NUM_MASTERS-1:0] o_sysp_sel,
  output logic [NUM_MASTERS-1:0] o_abort_resp,
  output logic [NUM_MASTERS-1:0] o_abort_ready,
  // Arbitration result per slave
  output logic [NUM_SLAVES*NUM_MASTERS-1:0] o_grant,
  // External bus chip selects
  output logic [7:0] o_ext_chip_select_n,
  // Boot state
  output logic o_boot_from_rom,
  output logic [3:0] o_ext_boot_cfg,
  output logic [NUM_MASTERS-1:0] o_remap_active
);

  // Strap synchroniser and the value caught after reset
  logic bms_meta_reg;
  logic bms_sync_reg;
  logic rst_seen_reg;
  logic boot_sel_reg;
  logic [NUM_MASTERS-1:0] remap_reg;

  // Per-master combinational decode results
  wire [NUM_MASTERS*NUM_SLAVES-1:0] dec_sel;
  wire [NUM_MASTERS*8-1:0] dec_cs_n;
  wire [NUM_MASTERS-1:0] dec_abort;
  wire [NUM_MASTERS-1:0] dec_sysp;
  wire [NUM_MASTERS-1:0] take;

  // Registered data phase state
  logic [NUM_MASTERS*NUM_SLAVES-1:0] sel_reg;
  logic [NUM_MASTERS*8-1:0] cs_n_reg;
  logic [NUM_MASTERS-1:0] sysp_reg;

  // Arbiter requests and grants, slave-major
  wire [NUM_SLAVES*NUM_MASTERS-1:0] arb_req;
  wire [NUM_SLAVES*NUM_MASTERS-1:0] arb_grant;

  // Chip selects of the external bus owner
  logic [7:0] ext_cs_n_reg;
  logic [7:0] ext_cs_n_next;

  // Outputs of the abort sequencers
  logic [NUM_MASTERS-1:0] err_resp_reg;
  logic [NUM_MASTERS-1:0] err_ready_reg;

  // Strap pin crosses in through two flip-flops, no reset needed
  always_ff @(posedge i_clock) begin
    bms_meta_reg <= i_boot_memory_select;
    bms_sync_reg <= bms_meta_reg;
  end

  // Catch the strap on the first edge after reset is released
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rst_seen_reg <= 1'b1;
      boot_sel_reg <= `BMX_BOOT_SEL_RST;
    end else begin
      rst_seen_reg <= 1'b0;
      if (rst_seen_reg) begin
        boot_sel_reg <= bms_sync_reg;
      end
    end
  end

  // Remap follows software only once reset is gone
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      remap_reg <= `BMX_REMAP_RST;
    end else begin
      remap_reg <= i_remap_ctrl;
    end
  end

  // Address phase taken when valid and the bus is ready
  assign take = i_htrans_valid & i_hready;

  // One decoder per master; only the processor masters alias boot
  genvar gm;
  generate
    for (gm = 0; gm < NUM_MASTERS; gm++) begin : g_master
      bmx_dec_if dif();

      assign dif.addr = i_haddr[gm*32 +: 32];
      assign dif.valid = i_htrans_valid[gm];
      assign dif.remap = remap_reg[gm];
      assign dif.boot_rom = boot_sel_reg;
      assign dec_sel[gm*NUM_SLAVES +: NUM_SLAVES] = dif.sel;
      assign dec_cs_n[gm*8 +: 8] = dif.cs_n;
      assign dec_abort[gm] = dif.abort;
      assign dec_sysp[gm] = dif.sysp;

      bmx_decoder #(
        .BOOT_ALIAS(gm < NUM_BOOT_MASTERS)
      ) u_dec (
        .dif(dif.dec)
      );

      // Two-cycle error answer for an aborted access
      bmx_pkg::bmx_err_state_t err_state_reg;
      bmx_pkg::bmx_err_state_t err_state_next;

      always_comb begin
        err_state_next = err_state_reg;
        case (err_state_reg)
          bmx_pkg::BMX_ERR_IDLE: begin
            if (take[gm] && dec_abort[gm]) begin
              err_state_next = bmx_pkg::BMX_ERR_FIRST;
            end
          end
          bmx_pkg::BMX_ERR_FIRST: begin
            err_state_next = bmx_pkg::BMX_ERR_SECOND;
          end
          bmx_pkg::BMX_ERR_SECOND: begin
            err_state_next = bmx_pkg::BMX_ERR_IDLE;
          end
          default: begin
            err_state_next = bmx_pkg::BMX_ERR_IDLE;
          end
        endcase
      end

      // Error state and its registered outputs
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          err_state_reg <= bmx_pkg::BMX_ERR_IDLE;
          err_resp_reg[gm] <= 1'b0;
          err_ready_reg[gm] <= 1'b0;
        end else begin
          err_state_reg <= err_state_next;
          err_resp_reg[gm] <=
            (err_state_next != bmx_pkg::BMX_ERR_IDLE);
          err_ready_reg[gm] <=
            (err_state_next == bmx_pkg::BMX_ERR_SECOND);
        end
      end

      // Data phase selects, reloaded on every ready cycle, held while not ready
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          sel_reg[gm*NUM_SLAVES +: NUM_SLAVES] <= '0;
          cs_n_reg[gm*8 +: 8] <= 8'hFF;
          sysp_reg[gm] <= 1'b0;
        end else if (i_hready[gm]) begin
          sel_reg[gm*NUM_SLAVES +: NUM_SLAVES] <=
            dec_sel[gm*NUM_SLAVES +: NUM_SLAVES];
          cs_n_reg[gm*8 +: 8] <= dec_cs_n[gm*8 +: 8];
          sysp_reg[gm] <= dec_sysp[gm];
        end
      end
    end
  endgenerate

  // Transpose master-major selects into slave-major requests
  genvar gs;
  genvar gr;
  generate
    for (gs = 0; gs < NUM_SLAVES; gs++) begin : g_slave
      for (gr = 0; gr < NUM_MASTERS; gr++) begin : g_req
        assign arb_req[gs*NUM_MASTERS + gr] =
          dec_sel[gr*NUM_SLAVES + gs];
      end

      // Independent arbiter and policy for each slave
      bmx_arbiter #(
        .NUM_MASTERS(NUM_MASTERS)
      ) u_arb (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_req(arb_req[gs*NUM_MASTERS +: NUM_MASTERS]),
        .i_busy(i_slave_busy[gs]),
        .i_mode(i_arb_mode[gs*2 +: 2]),
        .i_fixed_master(i_arb_fixed_master[gs*3 +: 3]),
        .o_grant(arb_grant[gs*NUM_MASTERS +: NUM_MASTERS])
      );
    end
  endgenerate

  // External chip selects come from the master owning slave three
  always_comb begin
    int m;
    m = 0;
    ext_cs_n_next = 8'hFF;
    for (m = 0; m < NUM_MASTERS; m++) begin
      if (arb_grant[`BMX_SLV_EBI*NUM_MASTERS + m] &&
          sel_reg[m*NUM_SLAVES + `BMX_SLV_EBI]) begin
        ext_cs_n_next = cs_n_reg[m*8 +: 8];
      end
    end
  end

  // External chip select register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ext_cs_n_reg <= 8'hFF;
    end else begin
      ext_cs_n_reg <= ext_cs_n_next;
    end
  end

  // Boot configuration for an external boot memory
  logic [3:0] ext_boot_cfg_reg;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ext_boot_cfg_reg <= 4'h0;
    end else begin
      ext_boot_cfg_reg[`BMX_EBOOT_SLOW_CLK] <= !boot_sel_reg;
      ext_boot_cfg_reg[`BMX_EBOOT_BYTE_SEL] <= !boot_sel_reg;
      ext_boot_cfg_reg[`BMX_EBOOT_BUS16] <= !boot_sel_reg;
      ext_boot_cfg_reg[`BMX_EBOOT_RW_BY_CS] <= !boot_sel_reg;
    end
  end

  // Outputs straight from flip-flops
  assign o_slave_sel = sel_reg;
  assign o_sysp_sel = sysp_reg;
  assign o_abort_resp = err_resp_reg;
  assign o_abort_ready = err_ready_reg;
  assign o_grant = arb_grant;
  assign o_ext_chip_select_n = ext_cs_n_reg;
  assign o_boot_from_rom = boot_sel_reg;
  assign o_ext_boot_cfg = ext_boot_cfg_reg;
  assign o_remap_active = remap_reg;

endmodule
